// ==== devctl_params.svh ====
// constants for the device control and status register pair
`ifndef DEVCTL_PARAMS_SVH
`define DEVCTL_PARAMS_SVH

// ==========================================
// address map
`define DEVCTL_OFFSET 32'h0000_00C8

// ==========================================
// control half field positions
`define CORR_EN_BIT 0
`define NONFATAL_EN_BIT 1
`define FATAL_EN_BIT 2
`define UNSUPP_EN_BIT 3
`define ERR_EN_LSB 0
`define ERR_EN_MSB 3
`define RELAXED_ORD_BIT 4
`define PAYLOAD_LSB 5
`define PAYLOAD_MSB 7
`define EXT_TAG_BIT 8
`define PHANTOM_BIT 9
`define AUX_PM_EN_BIT 10
`define NO_SNOOP_BIT 11
`define READ_REQ_LSB 12
`define READ_REQ_MSB 14

// ==========================================
// status half field positions
`define ERR_FLAG_LSB 16
`define ERR_FLAG_MSB 19
`define AUX_DET_BIT 20
`define TX_PEND_BIT 21

// ==========================================
// reset values
`define ERR_EN_RST 4'h0
`define PAYLOAD_RST 3'h0
`define AUX_PM_EN_RST 1'h0
`define ERR_FLAG_RST 4'h0
`define AUX_DET_RST 1'h1

// ==========================================
// bus encodings
`define HRESP_OKAY 1'h0
`define HSIZE_WORD 3'h2

`endif

// ==== devctl_pkg.sv ====
// types shared by the device control and status register pair
package devctl_pkg;

   // ==========================================
   // data phase tracking of the bus slave
   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_WRITE = 3'h2,
      PH_READ = 3'h4
   } phase_t;

   typedef logic [3:0] errvec_t;
   typedef logic [2:0] payload_t;

endpackage

// ==== pcie_switch_device_ctrl_status.sv ====
// device control and device status register pair of one switch port
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`include "devctl_params.svh"

module pcie_switch_device_ctrl_status (
   input wire logic clock,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // error detection pulses, order correctable, non-fatal, fatal, unsupported
   input wire logic [3:0] errDetect,
   input wire logic [2:0] maxPayloadSupported,
   input wire logic auxPowerPin,
   // control outputs
   output logic [3:0] errReportEnable,
   output logic [2:0] maxPayloadSize,
   output logic auxPowerPmEnable
);

   // ==========================================
   // decode helpers
   // only the word index is compared, so byte offsets alias to the word
   function automatic logic regHit(input logic [31:0] addr);
      regHit = (addr[31:2] == 30'(`DEVCTL_OFFSET >> 2));
   endfunction

   function automatic logic [2:0] clampPayload(input logic [2:0] code, input logic [2:0] lim);
      clampPayload = (code > lim) ? lim : code;
   endfunction

   // ==========================================
   // aux power pin synchroniser
   // the pin is asynchronous; only the second flop feeds the read path
   logic auxMeta_r;
   logic auxSync_r;
   logic auxMeta_nxt;
   logic auxSync_nxt;

   always_comb begin
      auxMeta_nxt = auxPowerPin;
      auxSync_nxt = auxMeta_r;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         auxMeta_r <= `AUX_DET_RST;
         auxSync_r <= `AUX_DET_RST;
      end else begin
         auxMeta_r <= auxMeta_nxt;
         auxSync_r <= auxSync_nxt;
      end
   end

   // ==========================================
   // bus slave: address phase capture
   logic [31:0] addr_r;
   logic [31:0] addr_nxt;
   devctl_pkg::phase_t phase_r;
   devctl_pkg::phase_t phase_nxt;
   logic addrValid;
   logic rdStall;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic wrHit;

   devctl_pkg::errvec_t errEnable_r;
   devctl_pkg::errvec_t errEnable_nxt;
   devctl_pkg::payload_t payload_r;
   devctl_pkg::payload_t payload_nxt;
   logic auxPmEn_r;
   logic auxPmEn_nxt;
   devctl_pkg::errvec_t errFlag_r;
   devctl_pkg::errvec_t errFlag_nxt;

   // a read right behind a write would sample stale contents, so it waits one cycle
   assign addrValid = hsel && htrans[1] && hready;
   assign rdStall = (phase_r == devctl_pkg::PH_WRITE) && hsel && htrans[1] && !hwrite;
   // hreadyout does not depend on hready, so tying them together forms no loop
   assign hreadyout = !rdStall;
   assign hresp = `HRESP_OKAY;
   assign hrdata = rdata_r;
   assign wrHit = (phase_r == devctl_pkg::PH_WRITE) && regHit(addr_r);

   // every field not placed below stays zero from the initial clear
   function automatic logic [31:0] readWord(
      input logic [3:0] en,
      input logic [2:0] pay,
      input logic aux,
      input logic [3:0] flag,
      input logic det
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`ERR_EN_MSB:`ERR_EN_LSB] = en;
      w[`PAYLOAD_MSB:`PAYLOAD_LSB] = pay;
      w[`AUX_PM_EN_BIT] = aux;
      w[`ERR_FLAG_MSB:`ERR_FLAG_LSB] = flag;
      w[`AUX_DET_BIT] = det;
      readWord = w;
   endfunction

   always_comb begin
      addr_nxt = addr_r;
      phase_nxt = devctl_pkg::PH_IDLE;
      rdata_nxt = rdata_r;
      // a pending data phase only blocks a new address phase in the stalled read
      case (phase_r)
         devctl_pkg::PH_IDLE,
         devctl_pkg::PH_WRITE,
         devctl_pkg::PH_READ: begin
            if (addrValid && !rdStall) begin
               addr_nxt = haddr;
               if (hwrite) begin
                  phase_nxt = devctl_pkg::PH_WRITE;
               end else begin
                  phase_nxt = devctl_pkg::PH_READ;
                  // unmapped reads return zero
                  if (regHit(haddr)) begin
                     rdata_nxt = readWord(errEnable_r, payload_r, auxPmEn_r,
                                          errFlag_r, auxSync_r);
                  end else begin
                     rdata_nxt = 32'h0000_0000;
                  end
               end
            end
         end
         default: begin
            phase_nxt = devctl_pkg::PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         addr_r <= 32'h0000_0000;
         phase_r <= devctl_pkg::PH_IDLE;
         rdata_r <= 32'h0000_0000;
      end else begin
         addr_r <= addr_nxt;
         phase_r <= phase_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================
   // control half
   // read-only and reserved bits of the written word are simply not stored
   always_comb begin
      errEnable_nxt = errEnable_r;
      payload_nxt = payload_r;
      auxPmEn_nxt = auxPmEn_r;
      if (wrHit) begin
         errEnable_nxt = hwdata[`ERR_EN_MSB:`ERR_EN_LSB];
         // limit is a live input so strapping changes take effect on next write
         payload_nxt = clampPayload(hwdata[`PAYLOAD_MSB:`PAYLOAD_LSB],
                                    maxPayloadSupported);
         auxPmEn_nxt = hwdata[`AUX_PM_EN_BIT];
      end
   end

   // the aux enable only has the one reset available here, so it clears with the rest
   always_ff @(posedge clock) begin
      if (!rstn) begin
         errEnable_r <= `ERR_EN_RST;
         payload_r <= `PAYLOAD_RST;
         auxPmEn_r <= `AUX_PM_EN_RST;
      end else begin
         errEnable_r <= errEnable_nxt;
         payload_r <= payload_nxt;
         auxPmEn_r <= auxPmEn_nxt;
      end
   end

   assign errReportEnable = errEnable_r;
   assign maxPayloadSize = payload_r;
   assign auxPowerPmEnable = auxPmEn_r;

   // ==========================================
   // status half: error detected flags
   // a detection held high keeps setting its flag, even against a clear
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gFlag
         always_comb begin
            errFlag_nxt[gi] = errFlag_r[gi];
            if (wrHit && hwdata[`ERR_FLAG_LSB + gi]) begin
               errFlag_nxt[gi] = 1'b0;
            end
            // set after clear so a same-cycle detection survives
            if (errDetect[gi]) begin
               errFlag_nxt[gi] = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rstn) begin
         errFlag_r <= `ERR_FLAG_RST;
      end else begin
         errFlag_r <= errFlag_nxt;
      end
   end

   // ==========================================
   // checks
   // one clock domain, so every check shares the clock, and all but a_reset_clear share the reset disable
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence sWriteHit;
      wrHit;
   endsequence

   sequence sReadHit;
      addrValid && !rdStall && !hwrite && regHit(haddr);
   endsequence

   a_enable_write: assert property (sWriteHit |=>
      errReportEnable == $past(hwdata[3:0]))
      else $error("reporting enables did not take the written value");

   a_payload_clamp: assert property (sWriteHit |=>
      maxPayloadSize == (($past(hwdata[7:5]) > $past(maxPayloadSupported)) ?
                         $past(maxPayloadSupported) : $past(hwdata[7:5])))
      else $error("payload size not clamped to supported limit");

   a_payload_hold: assert property (!wrHit |=> $stable(maxPayloadSize))
      else $error("payload size changed without a write");

   a_aux_enable: assert property (sWriteHit |=> auxPowerPmEnable == $past(hwdata[10]))
      else $error("aux power enable did not follow write");

   a_fixed_zero: assert property (sReadHit |=>
      (hrdata[4] == 1'b0) && (hrdata[9:8] == 2'h0) && (hrdata[15:11] == 5'h00) &&
      (hrdata[31:21] == 11'h000))
      else $error("hardwired field read back nonzero");

   a_flag_set: assert property (errDetect[0] |=> errFlag_r[0])
      else $error("correctable flag missed a detection");

   a_flags_logged: assert property ((errDetect != 4'h0) |=>
      ((errFlag_r & $past(errDetect)) == $past(errDetect)))
      else $error("error flag not set on detection");

   a_flag_clear: assert property ((sWriteHit and (errDetect == 4'h0)) |=>
      errFlag_r == ($past(errFlag_r) & ~$past(hwdata[19:16])))
      else $error("write-one-to-clear behaved wrongly");

   a_flag_sticky: assert property ((!wrHit && errDetect == 4'h0) |=> $stable(errFlag_r))
      else $error("error flag moved without cause");

   a_aux_detect: assert property (sReadHit |=> hrdata[20] == $past(auxSync_r))
      else $error("aux detected bit does not show synced pin");

   a_read_fields: assert property (sReadHit |=>
      (hrdata[3:0] == errReportEnable) && (hrdata[7:5] == maxPayloadSize))
      else $error("read data does not show control state");

   // ==========================================
   // reset and unmapped access checks
   sequence sMissRead;
      addrValid && !rdStall && !hwrite && !regHit(haddr);
   endsequence

   sequence sMissWrite;
      (phase_r == devctl_pkg::PH_WRITE) && !regHit(addr_r);
   endsequence

   // reset is the antecedent here, so this one check opts out of the default disable
   a_reset_clear: assert property (@(posedge clock)
      disable iff (1'b0) !rstn |=> (errReportEnable == `ERR_EN_RST) &&
      (maxPayloadSize == `PAYLOAD_RST) && (auxPowerPmEnable == `AUX_PM_EN_RST) &&
      (errFlag_r == `ERR_FLAG_RST) && (auxSync_r == `AUX_DET_RST) &&
      (hrdata == 32'h0000_0000))
      else $error("state did not return to reset values");

   a_unmapped_read: assert property (sMissRead |=> hrdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");

   a_unmapped_write: assert property (sMissWrite |=> $stable(errReportEnable) &&
      $stable(maxPayloadSize) && $stable(auxPowerPmEnable))
      else $error("unmapped write changed a control field");

   // control half checks
   a_enable_hold: assert property (!wrHit |=> $stable(errReportEnable))
      else $error("reporting enables changed without a write");

   a_auxen_hold: assert property (!wrHit |=> $stable(auxPowerPmEnable))
      else $error("aux power enable changed without a write");

   a_payload_limit: assert property (sWriteHit |=>
      maxPayloadSize <= $past(maxPayloadSupported))
      else $error("payload size above supported limit");

   // status half checks
   a_flag_update: assert property (sWriteHit |=>
      errFlag_r == (($past(errFlag_r) & ~$past(hwdata[19:16])) | $past(errDetect)))
      else $error("error flags wrong after a write");

   a_flag_accrue: assert property (!wrHit |=>
      errFlag_r == ($past(errFlag_r) | $past(errDetect)))
      else $error("error flags wrong without a write");

   // the first two edges after reset still show the synchroniser's reset value
   a_aux_sync: assert property (($past(rstn) && $past(rstn, 2)) |->
      auxSync_r == $past(auxPowerPin, 2))
      else $error("aux detect does not follow the pin after two flops");

   // read path checks
   a_read_status: assert property (sReadHit |=>
      (hrdata[19:16] == $past(errFlag_r)) && (hrdata[10] == $past(auxPowerPmEnable)))
      else $error("read data does not show status state");

endmodule

// ==== tb.sv ====
// self-checking bench for the device control and status register pair
`timescale 1ns/10ps
`include "devctl_params.svh"

module tb;
   // ==========================================
   // stimulus and observed signals
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic auxPowerPin = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic [3:0] errDetect = 4'h0;
   logic [2:0] maxPayloadSupported = 3'h7;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:0] errReportEnable;
   logic [2:0] maxPayloadSize;
   logic auxPowerPmEnable;
   int errors = 0;
   int n_checks = 0;
   // expected register contents
   logic [3:0] en = 4'h0;
   logic [2:0] pay = 3'h0;
   logic aux = 1'b0;
   logic [3:0] fl = 4'h0;
   logic ad = 1'b1;
   logic [2:0] sup;
   logic [31:0] q;
   logic [31:0] d;

   always #2 clock = ~clock;

   // single slave, so its ready is the bus ready
   pcie_switch_device_ctrl_status u_dut (.clock(clock), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .errDetect(errDetect), .maxPayloadSupported(maxPayloadSupported),
      .auxPowerPin(auxPowerPin), .errReportEnable(errReportEnable),
      .maxPayloadSize(maxPayloadSize), .auxPowerPmEnable(auxPowerPmEnable));

   // ==========================================
   // reference model
   function automatic logic [31:0] expw();
      logic [31:0] w;
      w = 32'h0;
      w[3:0] = en;
      w[7:5] = pay;
      w[10] = aux;
      w[19:16] = fl;
      w[20] = ad;
      return w;
   endfunction

   // ==========================================
   // checking and bus tasks
   task automatic wrap_up();
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // looks at ready mid-cycle so the value is settled before the sampling edge
   task automatic wait_rdy(output logic [31:0] r);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         errors++;
         wrap_up();
      end
      r = hrdata;
      chk({31'h0, hresp}, {31'h0, `HRESP_OKAY});
      @(posedge clock);
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
      logic [31:0] x;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy(x);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(r);
   endtask

   // det marks detections held high across the whole write
   task automatic wr(input logic [31:0] wd, input logic [3:0] det);
      xfer(1'b1, `DEVCTL_OFFSET, wd, q);
      en = wd[3:0];
      pay = (wd[7:5] > sup) ? sup : wd[7:5];
      aux = wd[10];
      fl = (fl & ~wd[19:16]) | det;
   endtask

   task automatic rd_chk();
      xfer(1'b0, `DEVCTL_OFFSET, 32'h0, q);
      chk(q, expw());
      chk({24'h0, errReportEnable, maxPayloadSize, auxPowerPmEnable},
          {24'h0, en, pay, aux});
   endtask

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(90));
      sup = 3'h7;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd_chk();
      // random writes, corners first: all ones with no headroom, all ones at top limit
      for (int i = 0; i < 24; i++) begin
         d = $urandom();
         sup = 3'($urandom());
         if (i == 0) begin
            d = 32'hFFFF_FFFF;
            sup = 3'h0;
         end
         if (i == 1) begin
            d = 32'hFFFF_FFFF;
            sup = 3'h7;
         end
         maxPayloadSupported <= sup;
         wr(d, 4'h0);
         rd_chk();
      end
      // flags log with every reporting enable off
      wr(32'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         errDetect <= 4'h1 << i;
         @(posedge clock);
         errDetect <= 4'h0;
         fl[i] = 1'b1;
         rd_chk();
      end
      wr(32'h0, 4'h0);
      rd_chk();
      errDetect <= 4'hF;
      wr(32'h000F_0000, 4'hF);
      errDetect <= 4'h0;
      rd_chk();
      wr(32'h000F_0000, 4'h0);
      rd_chk();
      // unmapped word: write ignored, read zero
      xfer(1'b1, `DEVCTL_OFFSET + 32'h4, 32'hFFFF_FFFF, q);
      xfer(1'b0, `DEVCTL_OFFSET + 32'h4, 32'h0, q);
      chk(q, 32'h0);
      rd_chk();
      // aux power removed, seen after the synchroniser
      auxPowerPin <= 1'b0;
      repeat (4) @(posedge clock);
      ad = 1'b0;
      rd_chk();
      // mid-run reset with state set and the pin low: aux detect shows its reset value first
      errDetect <= 4'hF;
      @(posedge clock);
      errDetect <= 4'h0;
      fl = 4'hF;
      wr(32'h0000_04EF, 4'h0);
      rd_chk();
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      en = 4'h0;
      pay = 3'h0;
      aux = 1'b0;
      fl = 4'h0;
      ad = 1'b1;
      rd_chk();
      ad = 1'b0;
      rd_chk();
      wrap_up();
   end
endmodule
